//--- design/adcot_cfg.svh
`ifndef ADCOT_CFG_SVH
`define ADCOT_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADCOT_ADDR_W         9
`define ADCOT_REG_CHAN_SEL   9'h005
`define ADCOT_REG_POWER      9'h008
`define ADCOT_REG_STABILIZER 9'h009
`define ADCOT_REG_CLK_DIV    9'h00B
`define ADCOT_REG_TEST       9'h00D
`define ADCOT_REG_BIST       9'h00E
`define ADCOT_REG_OUT_MODE   9'h014
`define ADCOT_REG_OUT_PHASE  9'h016
`define ADCOT_REG_BIST_RES   9'h024
`define ADCOT_REG_SYNC       9'h100

// ****************************************************************
// field positions
// ****************************************************************
`define ADCOT_OUT_DIS_BIT    4
`define ADCOT_BIST_EN_BIT    0
`define ADCOT_GENERATOR_RESTART_BIT_BIT  2
`define ADCOT_BIST_PASS_BIT  0
`define ADCOT_PN_SHORT_RST   4
`define ADCOT_PN_LONG_RST    5
`define ADCOT_SYNC_EN_BIT    1
`define ADCOT_SYNC_FIRST_BIT 2
`define ADCOT_DCO_INV_BIT    7

// ****************************************************************
// reset values
// ****************************************************************
`define ADCOT_CHAN_SEL_RST   2'h3
`define ADCOT_OUT_MODE_RST   8'h00
`define ADCOT_BYTE_RST       8'h00

// ****************************************************************
// timing counts
// ****************************************************************
`define ADCOT_LATENCY        9
`define ADCOT_BIST_LEN       10'h200
`define ADCOT_DIV_MAX        8

`endif

//--- design/adcot_pkg.sv
package adcot_pkg;

	localparam int DATA_W = 14;

	typedef enum logic [1:0] {
		ADCOT_FMT_OFFSET = 2'h0,
		ADCOT_FMT_TWOS   = 2'h1,
		ADCOT_FMT_GRAY   = 2'h2
	} adcot_fmt_t;

	typedef enum logic [1:0] {
		ADCOT_PWR_NORMAL  = 2'h0,
		ADCOT_PWR_DOWN    = 2'h1,
		ADCOT_PWR_STANDBY = 2'h2
	} adcot_pwr_t;

	typedef enum logic [3:0] {
		ADCOT_TEST_OFF      = 4'h0,
		ADCOT_TEST_MID      = 4'h1,
		ADCOT_TEST_POS_FS   = 4'h2,
		ADCOT_TEST_NEG_FS   = 4'h3,
		ADCOT_TEST_CHECKER  = 4'h4,
		ADCOT_TEST_PN_LONG  = 4'h5,
		ADCOT_TEST_PN_SHORT = 4'h6,
		ADCOT_TEST_TOGGLE   = 4'h7
	} adcot_test_t;

	typedef enum logic [1:0] {
		ADCOT_BIST_IDLE  = 2'b00,
		ADCOT_BIST_RUN   = 2'b01,
		ADCOT_BIST_CHECK = 2'b11
	} adcot_bist_state_t;

	// one converted word on its way through the pipeline
	typedef struct packed {
		logic              raw;
		logic              ovr;
		logic [DATA_W-1:0] code;
	} adcot_sample_t;

	// word as it leaves the output pins
	typedef struct packed {
		logic              ovr;
		logic [DATA_W-1:0] code;
	} adcot_out_t;

endpackage : adcot_pkg

//--- design/adcot_pn_gen.sv
`timescale 1ns/1ps
`default_nettype none

// fibonacci shift register, stepped once per sample
module adcot_pn_gen #(
	parameter int             WIDTH = 9,
	parameter logic [WIDTH-1:0] TAPS  = 9'h110,
	parameter logic [WIDTH-1:0] SEED  = 9'h1FF
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// control
	input  wire logic             restart_in,
	input  wire logic             step_in,
	// state
	output var  logic [WIDTH-1:0] state_out
);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_out <= SEED;
		end else if (restart_in) begin
			state_out <= SEED;
		end else if (step_in) begin
			state_out <= {state_out[WIDTH-2:0], ^(state_out & TAPS)};
		end
	end

endmodule : adcot_pn_gen

`default_nettype wire

//--- design/adcot_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcot_cfg.svh"

module adcot_top #(
	parameter int             CHANNELS       = 2,
	parameter logic [15:0]    BIST_SIGNATURE = 16'h0000
) (
	// clock and reset
	input  wire logic                                   clk_in,
	input  wire logic                                   reset_in,
	// serial port register access
	input  wire logic                                   serial_mode_in,
	input  wire logic [`ADCOT_ADDR_W-1:0]               reg_addr_in,
	input  wire logic [7:0]                             reg_wdata_in,
	input  wire logic                                   reg_write_in,
	input  wire logic                                   reg_read_in,
	output var  logic [7:0]                             reg_rdata_out,
	// control pins
	input  wire logic                                   power_down_pin_in,
	input  wire logic                                   output_disable_pin_in,
	input  wire logic                                   format_select_pin_in,
	input  wire logic                                   stabilizer_select_pin_in,
	input  wire logic                                   sync_in,
	// analog core
	input  wire adcot_pkg::adcot_out_t [CHANNELS-1:0]   core_data_in,
	output var  logic                                   core_enable_out,
	output var  logic                                   reference_on_out,
	output var  logic                                   duty_cycle_stabilizer_out,
	output var  logic                                   sample_strobe_out,
	// output pins
	output var  adcot_pkg::adcot_out_t [CHANNELS-1:0]   data_out,
	output var  logic [CHANNELS-1:0]                    data_oe_out,
	output var  logic [CHANNELS-1:0]                    data_clock_output_out,
	output var  logic [CHANNELS-1:0]                    data_clock_oe_out
);
	import adcot_pkg::*;

	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [DATA_W-1:0] format_code(input logic [DATA_W-1:0] code, input adcot_fmt_t fmt);
		logic [DATA_W-1:0] result;
		result = code;
		case (fmt)
			ADCOT_FMT_TWOS: result = code ^ {1'b1, {(DATA_W-1){1'b0}}};
			ADCOT_FMT_GRAY: result = code ^ (code >> 1);
			default: result = code;
		endcase
		return result;
	endfunction : format_code

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [DATA_W-1:0] word);
		logic [15:0] acc;
		acc = crc;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			acc = (acc[15] ^ word[i]) ? ((acc << 1) ^ 16'h1021) : (acc << 1);
		end
		return acc;
	endfunction : crc_step

	function automatic logic reg_hit(input logic [`ADCOT_ADDR_W-1:0] offset);
		return reg_write_in && (reg_addr_in == offset);
	endfunction : reg_hit

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [1:0]          chan_sel;
	adcot_pwr_t          power_mode;
	logic                stabilizer_reg;
	logic [2:0]          clk_div_reg;
	logic [7:0]          test_ctrl;
	logic [7:0]          bist_ctrl;
	logic [7:0]          out_mode [CHANNELS];
	logic [7:0]          out_phase;
	logic                bist_pass;
	logic [7:0]          sync_ctrl;
	logic                strap_taken;
	logic                strap_twos;
	logic                strap_stabilizer;
	logic                bist_done;
	logic                bist_start;

	assign bist_start = reg_write_in && (reg_addr_in == `ADCOT_REG_BIST) && reg_wdata_in[`ADCOT_BIST_EN_BIT];

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			chan_sel       <= `ADCOT_CHAN_SEL_RST;
			power_mode     <= ADCOT_PWR_NORMAL;
			stabilizer_reg <= 1'b1;
			clk_div_reg    <= 3'h0;
			test_ctrl      <= `ADCOT_BYTE_RST;
			out_phase      <= `ADCOT_BYTE_RST;
			sync_ctrl      <= `ADCOT_BYTE_RST;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				`ADCOT_REG_CHAN_SEL:   chan_sel <= reg_wdata_in[1:0];
				`ADCOT_REG_POWER:      power_mode <= adcot_pwr_t'(reg_wdata_in[1:0]);
				`ADCOT_REG_STABILIZER: stabilizer_reg <= reg_wdata_in[0];
				`ADCOT_REG_CLK_DIV:    clk_div_reg <= reg_wdata_in[2:0];
				`ADCOT_REG_TEST:       test_ctrl <= reg_wdata_in;
				`ADCOT_REG_OUT_PHASE:  out_phase <= reg_wdata_in;
				`ADCOT_REG_SYNC:       sync_ctrl <= reg_wdata_in;
				default: begin
				end
			endcase
		end
	end

	// output mode has one copy per channel, written through the channel mask
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int c = 0; c < CHANNELS; c++) begin
				out_mode[c] <= `ADCOT_OUT_MODE_RST;
			end
		end else if (reg_hit(`ADCOT_REG_OUT_MODE)) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (chan_sel[c % 2]) begin
					out_mode[c] <= reg_wdata_in;
				end
			end
		end
	end

	// hardware clear of the enable loses to a software write in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			bist_ctrl <= `ADCOT_BYTE_RST;
		end else if (reg_hit(`ADCOT_REG_BIST)) begin
			bist_ctrl <= reg_wdata_in;
		end else if (bist_done) begin
			bist_ctrl[`ADCOT_BIST_EN_BIT] <= 1'b0;
		end
	end

	// straps are caught on the first edge after reset release
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			strap_taken      <= 1'b0;
			strap_twos       <= 1'b0;
			strap_stabilizer <= 1'b1;
		end else if (!strap_taken) begin
			strap_taken      <= 1'b1;
			strap_twos       <= format_select_pin_in;
			strap_stabilizer <= stabilizer_select_pin_in;
		end
	end

	// ****************************************************************
	// power and format selection
	// ****************************************************************
	logic       powered_down;
	logic       standby;
	adcot_fmt_t fmt [CHANNELS];

	assign powered_down = power_down_pin_in || (serial_mode_in && power_mode == ADCOT_PWR_DOWN);
	assign standby      = serial_mode_in && power_mode == ADCOT_PWR_STANDBY && !power_down_pin_in;

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (!serial_mode_in) begin
				fmt[c] = strap_twos ? ADCOT_FMT_TWOS : ADCOT_FMT_OFFSET;
			end else begin
				fmt[c] = adcot_fmt_t'(out_mode[c][1:0]);
			end
		end
	end

	assign core_enable_out           = !powered_down && !standby;
	assign reference_on_out          = !powered_down;
	assign duty_cycle_stabilizer_out = serial_mode_in ? stabilizer_reg : strap_stabilizer;

	// ****************************************************************
	// sync and clock divider
	// ****************************************************************
	logic       sync_meta;
	logic       sync_q;
	logic       sync_prev;
	logic       sync_armed;
	logic       sync_valid;
	logic [2:0] div_count;
	logic       sample_stb;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync_meta <= 1'b0;
			sync_q    <= 1'b0;
			sync_prev <= 1'b0;
		end else begin
			sync_meta <= sync_in;
			sync_q    <= sync_meta;
			sync_prev <= sync_q;
		end
	end

	assign sync_valid = sync_q && !sync_prev && sync_ctrl[`ADCOT_SYNC_EN_BIT]
		&& (sync_armed || !sync_ctrl[`ADCOT_SYNC_FIRST_BIT]);

	// first-only mode re-arms on every write of the sync register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync_armed <= 1'b1;
		end else if (reg_hit(`ADCOT_REG_SYNC)) begin
			sync_armed <= 1'b1;
		end else if (sync_valid) begin
			sync_armed <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			div_count <= 3'h0;
		end else if (sync_valid) begin
			div_count <= 3'h0;
		end else if (div_count >= clk_div_reg) begin
			div_count <= 3'h0;
		end else begin
			div_count <= div_count + 3'h1;
		end
	end

	// no samples while powered down: the clock is stopped inside
	assign sample_stb        = (div_count >= clk_div_reg) && !sync_valid && core_enable_out;
	assign sample_strobe_out = sample_stb;

	// ****************************************************************
	// pattern generators
	// ****************************************************************
	logic [8:0]  pn_short;
	logic [22:0] pn_long;
	logic [22:0] pn_bist;
	logic        pattern_phase;
	adcot_bist_state_t bist_state;

	adcot_pn_gen #(.WIDTH(9), .TAPS(9'h110), .SEED(9'h1FF)) u_pn_short (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.restart_in (test_ctrl[`ADCOT_PN_SHORT_RST]),
		.step_in    (sample_stb),
		.state_out  (pn_short)
	);

	adcot_pn_gen #(.WIDTH(23), .TAPS(23'h420000), .SEED(23'h7FFFFF)) u_pn_long (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.restart_in (test_ctrl[`ADCOT_PN_LONG_RST]),
		.step_in    (sample_stb),
		.state_out  (pn_long)
	);

	adcot_pn_gen #(.WIDTH(23), .TAPS(23'h420000), .SEED(23'h7FFFFF)) u_pn_bist (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.restart_in (bist_start && reg_wdata_in[`ADCOT_GENERATOR_RESTART_BIT_BIT]),
		.step_in    (sample_stb && bist_state == ADCOT_BIST_RUN),
		.state_out  (pn_bist)
	);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pattern_phase <= 1'b0;
		end else if (sample_stb) begin
			pattern_phase <= !pattern_phase;
		end
	end

	// ****************************************************************
	// source select and nine-sample pipeline
	// ****************************************************************
	adcot_sample_t source [CHANNELS];
	adcot_sample_t pipe [CHANNELS][`ADCOT_LATENCY];

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			source[c] = '{raw: 1'b0, ovr: core_data_in[c].ovr, code: core_data_in[c].code};
			if (bist_state == ADCOT_BIST_RUN) begin
				source[c] = '{raw: 1'b0, ovr: 1'b0, code: pn_bist[DATA_W-1:0]};
			end else begin
				// fixed levels go through formatting, sequences do not
				case (adcot_test_t'(test_ctrl[3:0]))
					ADCOT_TEST_MID:      source[c] = '{raw: 1'b0, ovr: 1'b0, code: 14'h2000};
					ADCOT_TEST_POS_FS:   source[c] = '{raw: 1'b0, ovr: 1'b0, code: 14'h3FFF};
					ADCOT_TEST_NEG_FS:   source[c] = '{raw: 1'b0, ovr: 1'b0, code: 14'h0000};
					ADCOT_TEST_CHECKER:  source[c] = '{raw: 1'b1, ovr: 1'b0,
						code: pattern_phase ? 14'h1555 : 14'h2AAA};
					ADCOT_TEST_PN_LONG:  source[c] = '{raw: 1'b1, ovr: 1'b0, code: pn_long[DATA_W-1:0]};
					ADCOT_TEST_PN_SHORT: source[c] = '{raw: 1'b1, ovr: 1'b0, code: {pn_short[8:4], pn_short}};
					ADCOT_TEST_TOGGLE:   source[c] = '{raw: 1'b1, ovr: 1'b0,
						code: pattern_phase ? 14'h3FFF : 14'h0000};
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int c = 0; c < CHANNELS; c++) begin
				for (int s = 0; s < `ADCOT_LATENCY; s++) begin
					pipe[c][s] <= '0;
				end
			end
		end else if (sample_stb) begin
			for (int c = 0; c < CHANNELS; c++) begin
				pipe[c][0] <= source[c];
				for (int s = 1; s < `ADCOT_LATENCY; s++) begin
					pipe[c][s] <= pipe[c][s-1];
				end
			end
		end
	end

	// ****************************************************************
	// output stage and data clocks
	// ****************************************************************
	logic stb_d;

	// last pipeline stage is the output latch: nine strobes from capture
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			data_out[c].ovr  = pipe[c][`ADCOT_LATENCY-1].ovr;
			data_out[c].code = pipe[c][`ADCOT_LATENCY-1].raw ? pipe[c][`ADCOT_LATENCY-1].code
				: format_code(pipe[c][`ADCOT_LATENCY-1].code, fmt[c]);
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			stb_d <= 1'b0;
		end else begin
			stb_d <= sample_stb;
		end
	end

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			data_clock_output_out[c] = !stb_d ^ (serial_mode_in && out_phase[`ADCOT_DCO_INV_BIT]);
			data_oe_out[c] = !powered_down && !output_disable_pin_in
				&& !(serial_mode_in && out_mode[c][`ADCOT_OUT_DIS_BIT]);
			data_clock_oe_out[c] = data_oe_out[c];
		end
	end

	// ****************************************************************
	// self-test sequencer
	// ****************************************************************
	logic [9:0]  bist_count;
	logic [15:0] signature;

	assign bist_done = bist_state == ADCOT_BIST_CHECK;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			bist_state <= ADCOT_BIST_IDLE;
			bist_count <= 10'h000;
			signature  <= 16'hFFFF;
		end else begin
			case (bist_state)
				ADCOT_BIST_IDLE: begin
					if (bist_start) begin
						bist_state <= ADCOT_BIST_RUN;
						bist_count <= 10'h000;
						signature  <= 16'hFFFF;
					end
				end
				ADCOT_BIST_RUN: begin
					if (sample_stb) begin
						signature  <= crc_step(crc_step(signature, data_out[0].code),
							data_out[CHANNELS-1].code);
						bist_count <= bist_count + 10'h001;
						if (bist_count == `ADCOT_BIST_LEN - 10'h001) begin
							bist_state <= ADCOT_BIST_CHECK;
						end
					end
				end
				ADCOT_BIST_CHECK: bist_state <= ADCOT_BIST_IDLE;
				default: bist_state <= ADCOT_BIST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			bist_pass <= 1'b0;
		end else if (bist_state == ADCOT_BIST_IDLE && bist_start) begin
			bist_pass <= 1'b0;
		end else if (bist_done) begin
			bist_pass <= signature == BIST_SIGNATURE;
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_read_in) begin
			case (reg_addr_in)
				`ADCOT_REG_CHAN_SEL:   reg_rdata_out <= {6'h00, chan_sel};
				`ADCOT_REG_POWER:      reg_rdata_out <= {6'h00, power_mode};
				`ADCOT_REG_STABILIZER: reg_rdata_out <= {7'h00, stabilizer_reg};
				`ADCOT_REG_CLK_DIV:    reg_rdata_out <= {5'h00, clk_div_reg};
				`ADCOT_REG_TEST:       reg_rdata_out <= test_ctrl;
				`ADCOT_REG_BIST:       reg_rdata_out <= bist_ctrl;
				`ADCOT_REG_OUT_MODE:   reg_rdata_out <= chan_sel[0] ? out_mode[0] : out_mode[CHANNELS-1];
				`ADCOT_REG_OUT_PHASE:  reg_rdata_out <= out_phase;
				`ADCOT_REG_BIST_RES:   reg_rdata_out <= {7'h00, bist_pass};
				`ADCOT_REG_SYNC:       reg_rdata_out <= sync_ctrl;
				default:               reg_rdata_out <= 8'h00;
			endcase
		end
	end

endmodule : adcot_top

`default_nettype wire

//--- tb/adcot_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module adcot_monitor #(
	parameter int CHANNELS = 2
) (
	// clock and reset
	input wire logic				clk_in,
	input wire logic				reset_in,
	// control
	input wire logic				serial_mode_in,
	input wire logic				reg_write_in,
	input wire logic				reg_read_in,
	input wire logic				power_down_pin_in,
	input wire logic				output_disable_pin_in,
	// observed outputs
	input wire logic [7:0]				reg_rdata_out,
	input wire logic				core_enable_out,
	input wire logic				reference_on_out,
	input wire logic				sample_strobe_out,
	input wire adcot_pkg::adcot_out_t [CHANNELS-1:0]	data_out,
	input wire logic [CHANNELS-1:0]		data_oe_out,
	input wire logic [CHANNELS-1:0]		data_clock_output_out,
	input wire logic [CHANNELS-1:0]		data_clock_oe_out
);
	import adcot_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_pd_hiz: assert property (power_down_pin_in |-> data_oe_out == '0) else $error("driving in power-down");
	a_oeb_hiz: assert property (output_disable_pin_in |-> data_oe_out == '0 && data_clock_oe_out == '0)
		else $error("driving while disabled by pin");
	a_pd_core: assert property (power_down_pin_in |-> !core_enable_out && !reference_on_out)
		else $error("core awake in power-down");
	a_pin_wake: assert property (!power_down_pin_in && !serial_mode_in |-> core_enable_out)
		else $error("core asleep with pin low");
	a_idle_strobe: assert property (!core_enable_out |-> !sample_strobe_out) else $error("strobe while core off");
	a_ref_kept: assert property (core_enable_out |-> reference_on_out) else $error("core on without reference");
	a_dco_pair: assert property (data_clock_output_out[0] == data_clock_output_out[1])
		else $error("data clocks disagree");
	a_data_hold: assert property ($changed(data_out) |-> $past(sample_strobe_out) || $past(reg_write_in)
		|| $past(reset_in, 2)) else $error("data moved without strobe");
	a_rdata_hold: assert property (!$past(reg_read_in) |-> $stable(reg_rdata_out))
		else $error("read data moved without read");
endmodule : adcot_monitor
`default_nettype wire

//--- tb/adcot_capture.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// downstream capture register
// ****
module adcot_capture (
	// capture side
	input wire logic		dclk_in,
	input wire logic		oe_in,
	input wire adcot_pkg::adcot_out_t	word_in,
	// captured word
	output var adcot_pkg::adcot_out_t	word_out
);
	import adcot_pkg::*;
	// only a driven word is taken; a floating bus would latch garbage
	always_ff @(posedge dclk_in) begin
		if (oe_in) begin
			word_out <= word_in;
		end
	end
endmodule : adcot_capture
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb;
	import adcot_pkg::*;
	logic			clk_in, reset_in, serial_mode_in, reg_write_in, reg_read_in, sync_in;
	logic			power_down_pin_in, output_disable_pin_in, format_select_pin_in, stabilizer_select_pin_in;
	logic [8:0]		reg_addr_in;
	logic [7:0]		reg_wdata_in, reg_rdata_out, d, p;
	adcot_out_t [1:0]	core_data_in, data_out;
	adcot_out_t		cap_word;
	logic			core_enable_out, reference_on_out, duty_cycle_stabilizer_out, sample_strobe_out;
	logic [1:0]		data_oe_out, data_clock_output_out, data_clock_oe_out;
	int			err_count, checks, cycles;
	// test mode, format, core word, expected word
	logic [47:0]		rows [10] = '{48'h16_01_0000_3FFF, 48'h02_01_0000_1FFF, 48'h00_00_2000_2000,
		48'h00_01_2000_0000, 48'h00_01_0000_2000,
		48'h00_00_7FFF_7FFF, 48'h00_02_3FFF_2000, 48'h01_00_1234_2000, 48'h02_00_1234_3FFF,
		48'h03_00_1234_0000};

	adcot_top dut_u (.clk_in, .reset_in, .serial_mode_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
		.reg_read_in, .reg_rdata_out, .power_down_pin_in, .output_disable_pin_in, .format_select_pin_in,
		.stabilizer_select_pin_in, .sync_in, .core_data_in, .core_enable_out, .reference_on_out,
		.duty_cycle_stabilizer_out, .sample_strobe_out, .data_out, .data_oe_out, .data_clock_output_out,
		.data_clock_oe_out);
	adcot_capture cap_u (.dclk_in(data_clock_output_out[0]), .oe_in(data_oe_out[0]), .word_in(data_out[0]),
		.word_out(cap_word));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_write_in <= 1'b1;
		@(posedge clk_in);
		reg_write_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clk_in);
		reg_read_in <= 1'b0;
		cyc(1);
		v = reg_rdata_out;
	endtask : rd

	task automatic bist(input logic [7:0] v, output logic [7:0] res);
		wr(9'h00E, v);
		cyc(520);
		rd(9'h024, res);
	endtask : bist

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// hang guard, well above the planned run
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		{reg_write_in, reg_read_in, sync_in, power_down_pin_in, output_disable_pin_in} = '0;
		{format_select_pin_in, reg_addr_in, reg_wdata_in, core_data_in} = '0;
		{reset_in, serial_mode_in, stabilizer_select_pin_in} = 3'b111;
		{err_count, checks, cycles} = '0;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(9'h014, d);
		chk(d, 8'h00);
		rd(9'h1FF, d);
		chk(d, 8'h00);
		for (int i = 0; i < 10; i++) begin
			wr(9'h00D, rows[i][47:40]);
			wr(9'h014, rows[i][39:32]);
			core_data_in <= {2{rows[i][30:16]}};
			cyc(12);
			chk({1'b0, data_out[1], 1'b0, data_out[0]}, {2{rows[i][15:0]}});
		end
		$display("test rows done");
		wr(9'h00D, 8'h00);
		core_data_in <= {2{15'h0AAA}};
		cyc(12);
		@(posedge clk_in);
		core_data_in <= {2{15'h1555}};
		cyc(8);
		chk(data_out[0], 15'h0AAA);
		cyc(1);
		chk(data_out[0], 15'h1555);
		wr(9'h00B, 8'h01);
		cyc(20);
		chk(cap_word, data_out[0]);
		wr(9'h00B, 8'h00);
		$display("test latency done");
		serial_mode_in <= 1'b0;
		power_down_pin_in <= 1'b1;
		cyc(3);
		chk({data_oe_out, data_clock_oe_out, core_enable_out, reference_on_out}, 6'h00);
		@(posedge clk_in);
		power_down_pin_in <= 1'b0;
		cyc(3);
		chk({data_oe_out, data_clock_oe_out, core_enable_out, reference_on_out}, 6'h3F);
		@(posedge clk_in);
		output_disable_pin_in <= 1'b1;
		cyc(2);
		chk({data_oe_out, data_clock_oe_out}, 4'h0);
		@(posedge clk_in);
		output_disable_pin_in <= 1'b0;
		serial_mode_in <= 1'b1;
		wr(9'h008, 8'h01);
		cyc(2);
		chk({data_oe_out, core_enable_out, reference_on_out}, 4'h0);
		wr(9'h008, 8'h02);
		cyc(2);
		chk({data_oe_out, core_enable_out, reference_on_out}, 4'hD);
		wr(9'h008, 8'h00);
		wr(9'h014, 8'h10);
		cyc(1);
		chk({data_oe_out, data_clock_oe_out}, 4'h0);
		wr(9'h005, 8'h01);
		wr(9'h014, 8'h00);
		cyc(1);
		chk({data_oe_out, data_clock_oe_out}, 4'h5);
		wr(9'h005, 8'h03);
		wr(9'h014, 8'h00);
		$display("test enables done");
		wr(9'h00B, 8'h03);
		wr(9'h100, 8'h02);
		sync_in <= 1'b1;
		cyc(3);
		for (int k = 0; k < 4; k++) begin
			p[k] = sample_strobe_out;
			cyc(1);
		end
		chk(p[3:0], 4'h8);
		@(posedge clk_in);
		sync_in <= 1'b0;
		wr(9'h00B, 8'h00);
		wr(9'h100, 8'h00);
		$display("test sync done");
		reset_in <= 1'b1;
		serial_mode_in <= 1'b0;
		{format_select_pin_in, stabilizer_select_pin_in} <= 2'b10;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		cyc(2);
		chk({duty_cycle_stabilizer_out, data_out[0]}, {1'b0, 15'h2000});
		repeat (12) @(posedge clk_in);
		serial_mode_in <= 1'b1;
		$display("test reset done");
		bist(8'h05, p);
		rd(9'h00E, d);
		chk(d[0], 1'b0);
		bist(8'h01, d);
		chk(d[0], 1'b0);
		bist(8'h05, d);
		chk(d[0], p[0]);
		$display("test self-test done");
		tally_and_finish();
	end
endmodule : tb
bind adcot_top adcot_monitor #(.CHANNELS(CHANNELS)) mon_u (.clk_in, .reset_in, .serial_mode_in, .reg_write_in,
	.reg_read_in, .power_down_pin_in, .output_disable_pin_in, .reg_rdata_out, .core_enable_out,
	.reference_on_out, .sample_strobe_out, .data_out, .data_oe_out, .data_clock_output_out, .data_clock_oe_out);
`default_nettype wire
